// file: design/bsw_switch_top.sv
// Control logic of the four channel bus switch with serial target port.
`timescale 1ns/1ps
// Operation
// - Upstream pair reaches any of four channels.
// - Any channel combination may be enabled together.
// - Enables follow the control register only.
// - Only serial writes to us change selection.
// - Four active-low interrupt inputs, one per channel.
// - Interrupt output is AND of the inputs.
// - Interrupt output is active low.
// - Reset returns protocol machine to idle.
// - Reset disconnects every downstream channel.
// - All channels off until first write.
// - Serial clock may run static to 400kHz.
module bsw_switch_top #(
  parameter logic [4:0] ADDR_HI = bsw_pkg::ADDR_HI_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       scl_clk,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe,
  input  wire logic                       addr_strap_bit0,
  input  wire logic                       addr_strap_bit1,
  input  wire logic                       irq_in_ch0,
  input  wire logic                       irq_in_ch1,
  input  wire logic                       irq_in_ch2,
  input  wire logic                       irq_in_ch3,
  output logic                            irq_out_n,
  output logic [bsw_pkg::CH_NUM-1:0]      downstream_pair_en
);
  import bsw_pkg::*;

  bsw_line_type          line_s;
  bsw_line_type          line_q_r;
  bsw_state_type         st_r;
  logic [3:0]            cnt_r;
  logic [CTRL_W-1:0]     rx_r;
  logic [CTRL_W-1:0]     tx_r;
  logic [CTRL_W-1:0]     ctrl_rd;
  logic [CH_NUM-1:0]     irq_s;
  logic [1:0]            strap_s;
  logic                  smp_r;
  logic                  start_evt;
  logic                  stop_evt;
  logic                  fall_evt;
  logic                  bit_evt;
  logic                  addr_ok;

  // Link domain: data is caught on each rising serial clock. It needs no reset, so the
  // first bit after a reset release is never lost waiting for link clock edges.
  always_ff @(posedge scl_clk)
  begin
    smp_r <= sda_in;
  end

  // Line levels are synchronised for start, stop and falling edge detection.
  bsw_sync2 #(.W(2), .RST_VAL(2'h3)) u_line
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({scl_clk, sda_in}),
    .q     (line_s)
  );

  // Interrupt inputs, one per downstream pair, idle high.
  bsw_sync2 #(.W(CH_NUM), .RST_VAL(4'hf)) u_irq
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({irq_in_ch3, irq_in_ch2, irq_in_ch1, irq_in_ch0}),
    .q     (irq_s)
  );

  // Address straps set the two low target address bits.
  bsw_sync2 #(.W(2), .RST_VAL(2'h0)) u_strap
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({addr_strap_bit1, addr_strap_bit0}),
    .q     (strap_s)
  );

  // Previous line levels for start, stop and edge detection.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      line_q_r <= '{scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      line_q_r <= line_s;
    end
  end

  // Bus events; a bit is taken at the synchronised rise, long after the link sample settled.
  assign start_evt = line_q_r.scl & line_s.scl & line_q_r.sda & ~line_s.sda;
  assign stop_evt  = line_q_r.scl & line_s.scl & ~line_q_r.sda & line_s.sda;
  assign fall_evt  = line_q_r.scl & ~line_s.scl;
  assign bit_evt   = ~line_q_r.scl & line_s.scl;
  assign addr_ok   = rx_r[CTRL_W-1:1] == {ADDR_HI, strap_s};
  assign ctrl_rd   = {{(CTRL_W-CH_NUM){1'b0}}, downstream_pair_en};

  // Protocol state machine; no timeout, so any slow clock is followed.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r  <= ST_IDLE;
      cnt_r <= CNT_ZERO;
    end
    else if (start_evt)
    begin
      st_r  <= ST_ADDR;
      cnt_r <= CNT_ZERO;
    end
    else if (stop_evt)
    begin
      st_r <= ST_IDLE;
    end
    else
    begin
      case (st_r)
        ST_ADDR, ST_WDATA:
        begin
          if (bit_evt)
          begin
            cnt_r <= cnt_r + CNT_ONE;
            if (cnt_r == LAST_BIT)
            begin
              st_r <= (st_r == ST_ADDR) ? ST_AWAIT : ST_WAWAIT;
            end
          end
        end
        ST_AWAIT:
        begin
          if (fall_evt)
          begin
            st_r <= addr_ok ? ST_AACK : ST_IGN;
          end
        end
        ST_AACK:
        begin
          if (fall_evt)
          begin
            cnt_r <= CNT_ZERO;
            st_r  <= rx_r[RW_POS] ? ST_RDATA : ST_WDATA;
          end
        end
        ST_WAWAIT:
        begin
          if (fall_evt)
          begin
            st_r <= ST_WACK;
          end
        end
        ST_WACK:
        begin
          if (fall_evt)
          begin
            cnt_r <= CNT_ZERO;
            st_r  <= ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (bit_evt)
          begin
            cnt_r <= cnt_r + CNT_ONE;
          end
          else if (fall_evt && cnt_r == BYTE_BITS)
          begin
            st_r <= ST_RACK;
          end
        end
        ST_RACK:
        begin
          if (bit_evt)
          begin
            st_r <= smp_r ? ST_IGN : ST_RLOAD; // Not acknowledged ends the read.
          end
        end
        ST_RLOAD:
        begin
          if (fall_evt)
          begin
            cnt_r <= CNT_ZERO;
            st_r  <= ST_RDATA;
          end
        end
        ST_IDLE, ST_IGN:
        begin
          st_r <= st_r;
        end
        default:
        begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive shift register for address and write bytes.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_r <= CTRL_RST;
    end
    else if (bit_evt && (st_r == ST_ADDR || st_r == ST_WDATA))
    begin
      rx_r <= {rx_r[CTRL_W-2:0], smp_r};
    end
  end

  // Transmit shift register for reads of the control register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_r <= CTRL_RST;
    end
    else if (fall_evt && (st_r == ST_AACK || st_r == ST_RLOAD))
    begin
      tx_r <= ctrl_rd;
    end
    else if (fall_evt && st_r == ST_RDATA)
    begin
      tx_r <= {tx_r[CTRL_W-2:0], 1'b0};
    end
  end

  // Data line drive: set only while the serial clock is low; start and stop release it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sda_oe <= 1'b0;
    end
    else if (start_evt || stop_evt)
    begin
      sda_oe <= 1'b0;
    end
    else if (fall_evt)
    begin
      case (st_r)
        ST_AWAIT:  sda_oe <= addr_ok;
        ST_WAWAIT: sda_oe <= 1'b1;
        ST_AACK:   sda_oe <= rx_r[RW_POS] & ~ctrl_rd[MSB_POS];
        ST_RLOAD:  sda_oe <= ~ctrl_rd[MSB_POS];
        ST_RDATA:  sda_oe <= (cnt_r == BYTE_BITS) ? 1'b0 : ~tx_r[NEXT_POS];
        default:   sda_oe <= 1'b0;
      endcase
    end
  end

  // The data line is only ever pulled low.
  always_ff @(posedge clk)
  begin
    sda_out <= 1'b0;
  end

  // Channel enables load once the write byte's acknowledge clock ends.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      downstream_pair_en <= CTRL_RST[CH_NUM-1:0];
    end
    else if (fall_evt && st_r == ST_WACK && !start_evt && !stop_evt)
    begin
      downstream_pair_en <= rx_r[CH_NUM-1:0];
    end
  end

  // Combined interrupt: low whenever any channel input is low.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_out_n <= 1'b1;
    end
    else
    begin
      irq_out_n <= &irq_s;
    end
  end

  // Steps of a transfer: end of a write acknowledge and end of the address byte.
  sequence s_wack_end;
    st_r == ST_WACK && fall_evt && !start_evt && !stop_evt;
  endsequence

  sequence s_addr_end;
    st_r == ST_AWAIT && fall_evt && !start_evt && !stop_evt;
  endsequence

  // Any low interrupt input pulls the output low next cycle.
  property p_irq_low;
    @(posedge clk) disable iff (!rst_n)
    !(&irq_s) |=> !irq_out_n;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt output not low");

  // All inputs high release the output next cycle.
  property p_irq_high;
    @(posedge clk) disable iff (!rst_n)
    (&irq_s) |=> irq_out_n;
  endproperty
  a_irq_high: assert property (p_irq_high)
    else $error("interrupt output not released");

  // Right after reset every channel is off and the machine is idle.
  property p_reset_clear;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> downstream_pair_en == '0 && st_r == ST_IDLE && !sda_oe;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset did not clear state");

  // Enables change only at the end of a write acknowledge.
  property p_sel_only_ack;
    @(posedge clk) disable iff (!rst_n)
    $changed(downstream_pair_en) |-> $past(st_r) == ST_WACK && $past(fall_evt);
  endproperty
  a_sel_only_ack: assert property (p_sel_only_ack)
    else $error("selection changed outside acknowledge");

  // The written byte's low bits become the enables.
  property p_sel_value;
    @(posedge clk) disable iff (!rst_n)
    s_wack_end |=> downstream_pair_en == $past(rx_r[CH_NUM-1:0]);
  endproperty
  a_sel_value: assert property (p_sel_value)
    else $error("selection differs from written byte");

  // A foreign address is ignored and never acknowledged.
  property p_addr_miss;
    @(posedge clk) disable iff (!rst_n)
    s_addr_end and !addr_ok |=> st_r == ST_IGN && !sda_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address answered");

  // A matching address is acknowledged and held for several cycles.
  property p_addr_hit;
    @(posedge clk) disable iff (!rst_n)
    s_addr_end and addr_ok |=> (sda_oe && st_r == ST_AACK) [*8];
  endproperty
  a_addr_hit: assert property (p_addr_hit)
    else $error("own address not acknowledged");

  // A stop returns to idle and releases the data line.
  property p_stop_idle;
    @(posedge clk) disable iff (!rst_n)
    stop_evt && !start_evt |=> st_r == ST_IDLE && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return to idle");

  // A start always begins a fresh address byte.
  property p_start_addr;
    @(posedge clk) disable iff (!rst_n)
    start_evt |=> st_r == ST_ADDR && cnt_r == CNT_ZERO;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start did not restart address phase");

  // With no clock edge the machine waits indefinitely.
  property p_static_wait;
    @(posedge clk) disable iff (!rst_n)
    st_r == ST_AWAIT && !fall_evt && !start_evt && !stop_evt |=> st_r == ST_AWAIT;
  endproperty
  a_static_wait: assert property (p_static_wait)
    else $error("state left without a clock edge");
endmodule

// file: design/bsw_pkg.sv
// Constants and types shared by the four channel bus switch control logic.
package bsw_pkg;
  // Channel count and control byte shape.
  localparam int                CH_NUM    = 4;
  localparam int                CTRL_W    = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 8'h00;
  localparam int                RW_POS    = 0;
  localparam int                MSB_POS   = CTRL_W - 1;
  localparam int                NEXT_POS  = CTRL_W - 2;
  // Bit counter values within one byte.
  localparam logic [3:0]        CNT_ZERO  = 4'h0;
  localparam logic [3:0]        CNT_ONE   = 4'h1;
  localparam logic [3:0]        LAST_BIT  = 4'h7;
  localparam logic [3:0]        BYTE_BITS = 4'h8;
  // Default upper target address bits; the two low bits come from the straps.
  localparam logic [4:0]        ADDR_HI_DEF = 5'h1c;
  // Clock rates; no timeout exists, so a static serial clock is legal.
  localparam longint            CLK_HZ     = 200000000;
  localparam longint            SCL_MAX_HZ = 400000;
  localparam int                SCL_MIN_PERIOD_CYC = int'(CLK_HZ / SCL_MAX_HZ);

  // Protocol states of the serial target.
  typedef enum logic [3:0]
  {
    ST_IDLE,
    ST_ADDR,
    ST_AWAIT,
    ST_AACK,
    ST_WDATA,
    ST_WAWAIT,
    ST_WACK,
    ST_RDATA,
    ST_RACK,
    ST_RLOAD,
    ST_IGN
  } bsw_state_type;

  // Upstream line levels as seen in the system clock domain.
  typedef struct packed
  {
    logic scl;
    logic sda;
  } bsw_line_type;
endpackage

// file: design/bsw_sync2.sv
// Two flip-flop synchroniser for a group of level signals.
`timescale 1ns/1ps
module bsw_sync2 #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// file: dv/bsw_ctl_model.sv
// Upstream serial bus controller model for the switch testbench.
`timescale 1ns/1ps
module bsw_ctl_model #(
  parameter int HP = 1250
) (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  logic [7:0] res;
  event       done;
  // The bus idles with the clock high and the data released.
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  // Serial clock pulses, each a low phase then a high phase.
  task automatic pulse(input int n);
    repeat (n)
    begin
      #HP scl = 1'b0;
      #HP scl = 1'b1;
    end
  endtask
  // Start or repeated start; phases never shorter than the 400 kHz minimum.
  task automatic start();
    #(HP/2) sda_drv = 1'b1;
    #(HP/2) scl = 1'b1;
    #HP sda_drv = 1'b0;
    #HP scl = 1'b0;
  endtask
  // Stop condition leaves the bus idle.
  task automatic stop();
    #(HP/2) sda_drv = 1'b0;
    #(HP/2) scl = 1'b1;
    #HP sda_drv = 1'b1;
    #HP;
  endtask
  // Data moves mid low phase so it never races the clock edge.
  task automatic bit_io(input logic b, output logic r);
    #(HP/2) sda_drv = b;
    #(HP/2) scl = 1'b1;
    #(HP/2) r = sda;
    #(HP/2) scl = 1'b0;
  endtask
  // A write byte returns the target's acknowledge bit.
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], a);
    bit_io(1'b1, a);
    res = {7'h00, a};
    ->done;
  endtask
  // A read byte returns the data; ack low asks for more.
  task automatic recv(input logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, res[i]);
    bit_io(ack, a);
    ->done;
  endtask
endmodule

// file: dv/bsw_switch_top_bench.sv
// Self-checking testbench of the four channel bus switch.
`timescale 1ns/1ps
module bsw_switch_top_bench;
  import bsw_pkg::*;
  `define CMP(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: got %h want %h", $time, a, e); end end
  logic              clk = 1'b0;
  logic              rst_n, a0, a1, bt;
  logic [3:0]        irq, en_exp;
  logic [6:0]        adr;
  logic [7:0]        xb, xp, q[$];
  logic              scl, sda_drv, sda_out, sda_oe, irq_out_n;
  logic [CH_NUM-1:0] en;
  wire               sda;
  int                fail_count, checked, cyc;
  int                seed = 32'h9965;
  event              look;

  // System clock at 200 MHz.
  always #2.5 clk = ~clk;
  // Open-drain data wire with pull-up.
  assign sda = sda_drv & ~(sda_oe & ~sda_out);

  bsw_ctl_model ctl_i (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  bsw_switch_top bsw_switch_top_i (
    .clk(clk), .rst_n(rst_n), .scl_clk(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_bit0(a0), .addr_strap_bit1(a1),
    .irq_in_ch0(irq[0]), .irq_in_ch1(irq[1]), .irq_in_ch2(irq[2]),
    .irq_in_ch3(irq[3]), .irq_out_n(irq_out_n), .downstream_pair_en(en));

  // Monitor compares each bus result with the oldest note.
  always @(ctl_i.done)
  begin
    xb = q.pop_front();
    `CMP(ctl_i.res, xb)
  end
  // Monitor compares the pin levels with the oldest note.
  always @(look)
  begin
    xp = q.pop_front();
    `CMP({3'h0, irq_out_n, en}, xp)
  end

  // Hang guard a little above the expected run length.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic pin(input logic [7:0] e);
    q.push_back(e);
    ->look;
  endtask

  // One write with a pause of static clock between the bytes.
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic ok);
    ctl_i.start();
    q.push_back({7'h00, ~ok});
    ctl_i.send({a, 1'b0});
    if (ok)
    begin
      repeat (300) @(negedge clk);
      q.push_back(8'h00);
      ctl_i.send(d);
      en_exp = d[3:0];
    end
    ctl_i.stop();
    repeat (8) @(negedge clk);
    pin({3'h0, &irq, en_exp});
  endtask

  // One read of two bytes: the first is acknowledged, the second refused.
  task automatic rd();
    ctl_i.start();
    q.push_back(8'h00);
    ctl_i.send({adr, 1'b1});
    q.push_back({4'h0, en_exp});
    ctl_i.recv(1'b0);
    q.push_back({4'h0, en_exp});
    ctl_i.recv(1'b1);
    ctl_i.stop();
  endtask

  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    rst_n  = 1'b0;
    irq    = 4'hf;
    en_exp = 4'h0;
    cyc    = 0;
    {a1, a0} = 2'($random(seed));
    adr = {ADDR_HI_DEF, a1, a0};
    repeat (6) @(negedge clk);
    ctl_i.pulse(3);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    pin(8'h10);
    for (int i = 0; i < 3; i++)
      wr(adr, (i == 0) ? 8'hff : 8'($random(seed)), 1'b1);
    wr(adr ^ 7'h01, 8'h05, 1'b0);
    wr(adr ^ 7'h42, 8'h0a, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      irq = 4'($random(seed));
      repeat (4) @(negedge clk);
      pin({3'h0, &irq, en_exp});
    end
    // New strap levels move the target address; later transfers must follow it.
    {a1, a0} = ~{a1, a0};
    adr      = {ADDR_HI_DEF, a1, a0};
    repeat (4) @(negedge clk);
    ctl_i.start();
    q.push_back(8'h00);
    ctl_i.send({adr, 1'b0});
    repeat (3) ctl_i.bit_io(1'b0, bt);
    rst_n  = 1'b0;
    en_exp = 4'h0;
    ctl_i.pulse(4);
    pin(8'h10);
    // The bus returns to idle while reset holds, so release meets a quiet bus.
    ctl_i.stop();
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    wr(adr, 8'($random(seed)), 1'b1);
    rd();
    summarize();
  end
endmodule
